// [common/gom_cfg.svh]
// Purpose: constants for the pin output source multiplexer
// Assumes: included by its bare name
// Notes:   codes, offsets, field positions and reset values
`ifndef GOM_CFG_SVH
`define GOM_CFG_SVH

`define GOM_NUM_PINS        7
`define GOM_NUM_PORTS       2
`define GOM_GPIO_PER_PORT   4
// source group codes
`define GOM_SRC_PORT0       3'h0
`define GOM_SRC_PORT1       3'h1
`define GOM_SRC_DEVICE      3'h4
`define GOM_SRC_CSITX       3'h5
// device status function codes
`define GOM_DEV_VALUE       3'h0
`define GOM_DEV_LOCK_OR     3'h1
`define GOM_DEV_LOCK_AND    3'h2
`define GOM_DEV_PASS_AND    3'h3
`define GOM_DEV_FSYNC       3'h4
`define GOM_DEV_IRQ_HI      3'h5
`define GOM_DEV_IRQ_LO      3'h6
// transmit port function codes
`define GOM_TX_PASS_AND     3'h0
`define GOM_TX_PASS_OR      3'h1
`define GOM_TX_FV           3'h2
`define GOM_TX_LV           3'h3
`define GOM_TX_SYNC         3'h4
`define GOM_TX_IRQ          3'h5
// receive port function codes 4..7
`define GOM_RX_LOCK         3'h4
`define GOM_RX_PASS         3'h5
`define GOM_RX_FV           3'h6
`define GOM_RX_LV           3'h7
// register map, byte addresses
`define GOM_ADDR_PIN0       8'h00
`define GOM_ADDR_PORTCFG    8'h20
`define GOM_ADDR_STATUS     8'h24
`define GOM_ADDR_LAST_PIN   8'h18
// pin control word fields
`define GOM_F_EN            0
`define GOM_F_VAL           1
`define GOM_F_FUNC_LO       4
`define GOM_F_SRC_LO        8
// port config word fields
`define GOM_F_PORTEN_LO     0
`define GOM_F_TXSEL_LO      4
`define GOM_F_CNT_LO        8
`define GOM_F_DVP_LO        16
// reset values
`define GOM_PIN_RESET       32'h0000_0000
`define GOM_PORTCFG_RESET   32'h0000_0003
// bus responses
`define GOM_RESP_OKAY       2'h0
`define GOM_RESP_SLVERR     2'h2
// forward channel frames per refresh
`define GOM_FRAMES_1        3'h1
`define GOM_FRAMES_2        3'h2
`define GOM_FRAMES_34       3'h5

`endif

// [common/gom_pkg.sv]
// Purpose: types for the pin output source multiplexer
// Assumes: nothing
// Notes:   one control word per pin
package gom_pkg;
   // one pin's output configuration
   typedef struct packed {
      logic [2:0] srcGroup;   // pin_source_group
      logic [2:0] funcCode;   // pin_function_code
      logic       outValue;   // pin_output_value
      logic       outEnable;  // pin_output_enable
   } gom_pin_cfg_t;

   // per receive port status
   typedef struct packed {
      logic lock;
      logic pass;
      logic frameValid;
      logic lineValid;
   } gom_rx_stat_t;
endpackage

// [rtl/gom_output_mux.sv]
// Purpose: seven pin output multiplexer with forward channel gpio refresh
// Assumes: link-side inputs asynchronous, synchronised here; one clock
// Notes:   registers over axi4-lite, pins as three signals each
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`include "gom_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module gom_output_mux #(
   parameter int NPINS  = `GOM_NUM_PINS,
   parameter int NPORTS = `GOM_NUM_PORTS
) (
   input  wire logic                     clk,
   input  wire logic                     sys_rst,
   // axi4-lite slave
   input  wire logic [7:0]               s_axi_awaddr,
   input  wire logic                     s_axi_awvalid,
   output logic                          s_axi_awready,
   input  wire logic [31:0]              s_axi_wdata,
   input  wire logic [3:0]               s_axi_wstrb,
   input  wire logic                     s_axi_wvalid,
   output logic                          s_axi_wready,
   output logic [1:0]                    s_axi_bresp,
   output logic                          s_axi_bvalid,
   input  wire logic                     s_axi_bready,
   input  wire logic [7:0]               s_axi_araddr,
   input  wire logic                     s_axi_arvalid,
   output logic                          s_axi_arready,
   output logic [31:0]                   s_axi_rdata,
   output logic [1:0]                    s_axi_rresp,
   output logic                          s_axi_rvalid,
   input  wire logic                     s_axi_rready,
   // link and device side status, asynchronous
   input  wire logic [NPORTS*4-1:0]      remoteGpio,
   input  wire logic [NPORTS-1:0]        fwdFrameTick,
   input  wire logic [NPORTS*4-1:0]      rxStatus,
   input  wire logic                     frameSynchronization,
   input  wire logic                     deviceIrq,
   input  wire logic                     txIrq,
   input  wire logic                     txFrameValid,
   input  wire logic                     txLineValid,
   input  wire logic                     rxPortsSynced,
   // pins
   input  wire logic [NPINS-1:0]         gpioIn,
   output logic      [NPINS-1:0]         gpioOut,
   output logic      [NPINS-1:0]         gpioOe
);

   localparam int NSYNC = NPORTS*4 + NPORTS*4 + NPORTS + 5;

   // control words, one per pin
   gom_pkg::gom_pin_cfg_t pinCfg_q [NPINS];
   logic [NPORTS-1:0]  portEn_q;        // enabled receive ports
   logic [NPORTS-1:0]  txSel_q;         // ports feeding the tx pass
   logic [2*NPORTS-1:0] fcCount_q;      // linked_remote_input_count, 2b/port
   logic [NPORTS-1:0]  dvpMode_q;       // port serializer in parallel video mode

   // two-flop synchroniser, first stage read only by the second
   logic [NSYNC-1:0] meta_q;
   logic [NSYNC-1:0] sync_q;
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         meta_q <= {remoteGpio, rxStatus, fwdFrameTick, frameSynchronization, deviceIrq,
                    txIrq, txFrameValid, txLineValid};
         sync_q <= meta_q;
      end
   end

   logic [NPORTS*4-1:0] gpioS;
   logic [NPORTS*4-1:0] statS;
   logic [NPORTS-1:0]   tickS;
   logic fsyncS, devIrqS, txIrqS, fvS, lvS;
   assign {gpioS, statS, tickS, fsyncS, devIrqS, txIrqS, fvS, lvS} = sync_q;

   // rx-ports-synced goes through its own pair; kept separate for clarity
   logic syncM_q;
   logic syncS_q;
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         syncM_q <= 1'b0;
         syncS_q <= 1'b0;
      end
      else
      begin
         syncM_q <= rxPortsSynced;
         syncS_q <= syncM_q;
      end
   end

   // frames per refresh from the linked count (0->1, 1->2, 2/3->5)
   function automatic logic [2:0] framesPer(input logic [1:0] cnt);
      unique case (cnt)
         2'h0:    framesPer = `GOM_FRAMES_1;
         2'h1:    framesPer = `GOM_FRAMES_2;
         default: framesPer = `GOM_FRAMES_34;
      endcase
   endfunction

   // frame tick edge detect on the synchronised tick
   logic [NPORTS-1:0] tickD_q;
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         tickD_q <= '0;
      else
         tickD_q <= tickS;
   end

   // refresh counters and held remote values per port
   logic [2:0]          frameCnt_q [NPORTS];
   logic [NPORTS*4-1:0] heldGpio_q;
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         heldGpio_q <= '0;
         for (int p = 0; p < NPORTS; p++)
            frameCnt_q[p] <= 3'h0;
      end
      else
      begin
         for (int p = 0; p < NPORTS; p++)
         begin
            if (dvpMode_q[p])
            begin
               // parallel video serializers carry no remote inputs
               heldGpio_q[p*4 +: 4] <= 4'h0;
               frameCnt_q[p] <= 3'h0;
            end
            else if (tickS[p] && !tickD_q[p])
            begin
               // sample once per refresh period; latency fixed, jitter is the period
               if (frameCnt_q[p] + 3'h1 >= framesPer(fcCount_q[p*2 +: 2]))
               begin
                  frameCnt_q[p] <= 3'h0;
                  for (int g = 0; g < 4; g++)
                     // values beyond the linked count stay low
                     heldGpio_q[p*4+g] <= (g <= int'(fcCount_q[p*2 +: 2])) ? gpioS[p*4+g] : 1'b0;
               end
               else
                  frameCnt_q[p] <= frameCnt_q[p] + 3'h1;
            end
         end
      end
   end

   // aggregate status terms
   logic lockOr, lockAnd, passAnd, txPassAnd, txPassOr;
   always_comb
   begin
      lockOr    = 1'b0;
      lockAnd   = 1'b1;
      passAnd   = 1'b1;
      txPassAnd = 1'b1;
      txPassOr  = 1'b0;
      for (int p = 0; p < NPORTS; p++)
      begin
         if (portEn_q[p])
         begin
            lockOr  = lockOr  | statS[p*4+3];
            lockAnd = lockAnd & statS[p*4+3];
            passAnd = passAnd & statS[p*4+2];
         end
         if (txSel_q[p])
         begin
            txPassAnd = txPassAnd & statS[p*4+2];
            txPassOr  = txPassOr  | statS[p*4+2];
         end
      end
   end

   // per-pin source selection
   function automatic logic pick(input gom_pkg::gom_pin_cfg_t c);
      logic [2:0] port;
      port = c.srcGroup;
      pick = 1'b0;
      unique case (c.srcGroup)
         `GOM_SRC_PORT0, `GOM_SRC_PORT1:
            // any remote value from any port to any pin
            if (!c.funcCode[2])
               pick = heldGpio_q[port[0]*4 + c.funcCode[1:0]];
            else
               pick = statS[port[0]*4 + 3 - c.funcCode[1:0]];
         `GOM_SRC_DEVICE:
            unique case (c.funcCode)
               `GOM_DEV_VALUE:    pick = c.outValue;
               `GOM_DEV_LOCK_OR:  pick = lockOr;
               `GOM_DEV_LOCK_AND: pick = lockAnd;
               `GOM_DEV_PASS_AND: pick = passAnd;
               `GOM_DEV_FSYNC:    pick = fsyncS;
               `GOM_DEV_IRQ_HI:   pick = devIrqS;
               `GOM_DEV_IRQ_LO:   pick = !devIrqS;
               default:           pick = 1'b0;
            endcase
         `GOM_SRC_CSITX:
            unique case (c.funcCode)
               `GOM_TX_PASS_AND: pick = txPassAnd;
               `GOM_TX_PASS_OR:  pick = txPassOr;
               `GOM_TX_FV:       pick = fvS;
               `GOM_TX_LV:       pick = lvS;
               `GOM_TX_SYNC:     pick = syncS_q;
               `GOM_TX_IRQ:      pick = txIrqS;
               default:          pick = 1'b0;
            endcase
         default: pick = 1'b0;
      endcase
   endfunction

   // pin drivers, registered so the outputs come from flops
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         gpioOut <= '0;
         gpioOe  <= '0;
      end
      else
      begin
         for (int i = 0; i < NPINS; i++)
         begin
            gpioOe[i]  <= pinCfg_q[i].outEnable;
            gpioOut[i] <= pinCfg_q[i].outEnable & pick(pinCfg_q[i]);
         end
      end
   end

   // axi4-lite write: take address and data in either order
   logic       awHeld_q, wHeld_q;
   logic [7:0] awAddr_q;
   logic [31:0] wData_q;
   logic [3:0] wStrb_q;
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         awHeld_q <= 1'b0;
         wHeld_q  <= 1'b0;
         awAddr_q <= 8'h00;
         wData_q  <= 32'h0000_0000;
         wStrb_q  <= 4'h0;
      end
      else if (awHeld_q && wHeld_q)
      begin
         // commit cycle, both released
         awHeld_q <= 1'b0;
         wHeld_q  <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awHeld_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end
      end
   end

   // ready only while slot empty and no response pending
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end
      else
      begin
         s_axi_awready <= !awHeld_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid
                          && !(awHeld_q && wHeld_q);
         s_axi_wready  <= !wHeld_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid
                          && !(awHeld_q && wHeld_q);
      end
   end

   logic wrHit;
   assign wrHit = (awAddr_q <= `GOM_ADDR_LAST_PIN && awAddr_q[1:0] == 2'h0)
                  || awAddr_q == `GOM_ADDR_PORTCFG;

   // register writes, low byte lanes only matter
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         for (int i = 0; i < NPINS; i++)
            pinCfg_q[i] <= gom_pkg::gom_pin_cfg_t'(`GOM_PIN_RESET);
         {dvpMode_q, fcCount_q, txSel_q} <= '0;
         portEn_q <= NPORTS'(`GOM_PORTCFG_RESET);
      end
      else if (awHeld_q && wHeld_q)
      begin
         if (awAddr_q == `GOM_ADDR_PORTCFG)
         begin
            if (wStrb_q[0])
            begin
               portEn_q <= wData_q[`GOM_F_PORTEN_LO +: NPORTS];
               txSel_q  <= wData_q[`GOM_F_TXSEL_LO +: NPORTS];
            end
            if (wStrb_q[1])
               fcCount_q <= wData_q[`GOM_F_CNT_LO +: 2*NPORTS];
            if (wStrb_q[2])
               dvpMode_q <= wData_q[`GOM_F_DVP_LO +: NPORTS];
         end
         else if (wrHit)
         begin
            for (int i = 0; i < NPINS; i++)
               if (awAddr_q[4:2] == 3'(i))
               begin
                  if (wStrb_q[0])
                  begin
                     pinCfg_q[i].outEnable <= wData_q[`GOM_F_EN];
                     pinCfg_q[i].outValue  <= wData_q[`GOM_F_VAL];
                     pinCfg_q[i].funcCode  <= wData_q[`GOM_F_FUNC_LO +: 3];
                  end
                  if (wStrb_q[1])
                     pinCfg_q[i].srcGroup <= wData_q[`GOM_F_SRC_LO +: 3];
               end
         end
      end
   end

   // write response, one cycle after commit
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `GOM_RESP_OKAY;
      end
      else if (awHeld_q && wHeld_q)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wrHit ? `GOM_RESP_OKAY : `GOM_RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // read channel, answer one cycle after address taken
   function automatic logic [31:0] readWord(input logic [7:0] a);
      readWord = 32'h0000_0000;
      for (int i = 0; i < NPINS; i++)
         if (a == 8'(i*4))
            readWord = {16'h0000, 5'h00, pinCfg_q[i].srcGroup, 1'b0, pinCfg_q[i].funcCode,
                        2'h0, pinCfg_q[i].outValue, pinCfg_q[i].outEnable};
      if (a == `GOM_ADDR_PORTCFG)
         readWord = {14'h0000, dvpMode_q, 4'h0, fcCount_q, 2'h0, txSel_q, 2'h0, portEn_q};
      if (a == `GOM_ADDR_STATUS)
         readWord = {9'h000, gpioOut, heldGpio_q, statS};
   endfunction

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `GOM_RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= readWord(s_axi_araddr);
            s_axi_rresp  <= ((s_axi_araddr <= `GOM_ADDR_LAST_PIN && s_axi_araddr[1:0] == 2'h0)
                            || s_axi_araddr == `GOM_ADDR_PORTCFG || s_axi_araddr == `GOM_ADDR_STATUS)
                            ? `GOM_RESP_OKAY : `GOM_RESP_SLVERR;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // checks
   a_pin_disabled_low: assert property (@(posedge clk) disable iff (sys_rst)
      !pinCfg_q[0].outEnable |=> !gpioOut[0] && !gpioOe[0])
      else $error("disabled pin driven");
   a_reserved_group_low: assert property (@(posedge clk) disable iff (sys_rst)
      pinCfg_q[0].outEnable && pinCfg_q[0].srcGroup == 3'h2 |=> !gpioOut[0])
      else $error("reserved group not low");
   a_value_follows: assert property (@(posedge clk) disable iff (sys_rst)
      pinCfg_q[1].outEnable && pinCfg_q[1].srcGroup == `GOM_SRC_DEVICE
      && pinCfg_q[1].funcCode == `GOM_DEV_VALUE |=> gpioOut[1] == $past(pinCfg_q[1].outValue))
      else $error("programmed value not driven");
   a_irq_low_inverts: assert property (@(posedge clk) disable iff (sys_rst)
      pinCfg_q[2].outEnable && pinCfg_q[2].srcGroup == `GOM_SRC_DEVICE
      && pinCfg_q[2].funcCode == `GOM_DEV_IRQ_LO |=> gpioOut[2] == !$past(devIrqS))
      else $error("inverted irq wrong");
   a_fsync_on_pin: assert property (@(posedge clk) disable iff (sys_rst)
      pinCfg_q[3].outEnable && pinCfg_q[3].srcGroup == `GOM_SRC_DEVICE
      && pinCfg_q[3].funcCode == `GOM_DEV_FSYNC |=> gpioOut[3] == $past(fsyncS))
      else $error("frame sync not driven");
   a_dvp_refused: assert property (@(posedge clk) disable iff (sys_rst)
      dvpMode_q[0] |=> heldGpio_q[3:0] == 4'h0)
      else $error("dvp port value accepted");
   a_count_bounded: assert property (@(posedge clk) disable iff (sys_rst)
      frameCnt_q[0] < `GOM_FRAMES_34)
      else $error("refresh counter overrun");
   a_bresp_after_commit: assert property (@(posedge clk) disable iff (sys_rst)
      awHeld_q && wHeld_q |=> s_axi_bvalid)
      else $error("write response missing");
   a_rvalid_after_ar: assert property (@(posedge clk) disable iff (sys_rst)
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data missing");

endmodule // gom_output_mux

`default_nettype wire

// [verif/gom_far_model.sv]
// Purpose: far side model, remote serializers feeding forward values
// Assumes: both ports framed alike, one marker per frame
// Notes:   values move mid frame, away from the sampling edge
`timescale 1ns/10ps
`default_nettype none

module gom_far_model #(
   parameter int PERIOD = 8   // clk cycles per forward frame
) (
   input  wire logic       clk,
   input  wire logic [7:0] nextVal,
   output logic      [7:0] remoteGpio,
   output logic      [1:0] fwdFrameTick
);
   int cnt = 0;   // position inside the frame

   // marker high for the first half of each frame, so each level lasts >= 2 clk
   always_ff @(posedge clk)
   begin
      cnt          <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      fwdFrameTick <= {2{cnt < PERIOD / 2}};
      // new values only once a frame keeps toggling well under sampling
      if (cnt == PERIOD / 2)
      begin
         remoteGpio <= nextVal;
      end
   end
endmodule // gom_far_model

`default_nettype wire

// [verif/gom_output_mux_tb_top.sv]
// Purpose: self-checking bench for the pin output multiplexer
// Assumes: axi4-lite master here, far model feeds forward values
// Notes:   the four defined source groups, two reserved groups and every code are swept on random pins
`include "gom_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module gom_output_mux_tb_top;
   logic        clk = 1'b0;   // 50 ns period
   logic        sys_rst = 1'b1;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;   // always ready for answers
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [7:0]  remoteGpio, rxStatus = 8'h00, nextVal = 8'h00;
   logic [1:0]  fwdFrameTick;
   logic        frameSynchronization = 1'b0, deviceIrq = 1'b0, txIrq = 1'b0;
   logic        txFrameValid = 1'b0, txLineValid = 1'b0, rxPortsSynced = 1'b0;
   logic [6:0]  gpioIn = 7'h00, gpioOut, gpioOe, oeExp = 7'h00;
   logic [2:0]  grp [6] = '{3'h4, 3'h5, 3'h0, 3'h1, 3'h2, 3'h6};   // last two reserved
   int          err_total = 0, compares = 0;

   always #25 clk = ~clk;

   gom_output_mux gom_output_mux_inst (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .remoteGpio, .fwdFrameTick, .rxStatus, .frameSynchronization, .deviceIrq, .txIrq,
      .txFrameValid, .txLineValid, .rxPortsSynced, .gpioIn, .gpioOut, .gpioOe);

   gom_far_model gom_far_model_inst (.clk, .nextVal, .remoteGpio, .fwdFrameTick);

   // verdict in one place
   task automatic summarize;
      $display("compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         err_total++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // write: address and data offered together, each dropped once taken
   task automatic axiWr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (n > 200) begin err_total++; summarize(); end   // hung bus
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
   endtask

   task automatic axiRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (n > 200) begin err_total++; summarize(); end
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask

   // pin level expected for a source group and code; ports 0 and 1 both enabled
   function automatic logic expOut(input logic [2:0] s, input logic [2:0] f, input logic v);
      logic [1:0] lk;
      logic [1:0] ps;
      int         b;
      lk = {rxStatus[7], rxStatus[3]};
      ps = {rxStatus[6], rxStatus[2]};
      b = 4 * s[0];
      expOut = 1'b0;   // reserved codes stay low
      if (s == `GOM_SRC_DEVICE)
         case (f)
            3'h0: expOut = v;
            3'h1: expOut = |lk;
            3'h2: expOut = &lk;
            3'h3: expOut = &ps;
            3'h4: expOut = frameSynchronization;
            3'h5: expOut = deviceIrq;
            3'h6: expOut = ~deviceIrq;
            default: expOut = 1'b0;
         endcase
      else if (s == `GOM_SRC_CSITX)
         case (f)
            3'h0: expOut = &ps;
            3'h1: expOut = |ps;
            3'h2: expOut = txFrameValid;
            3'h3: expOut = txLineValid;
            3'h4: expOut = rxPortsSynced;
            3'h5: expOut = txIrq;
            default: expOut = 1'b0;
         endcase
      else if (s <= 3'h1)
         // one linked value per port: only the first carries data
         expOut = f[2] ? rxStatus[b + 7 - f] : (f == 3'h0 && nextVal[b]);
   endfunction

   initial
   begin
      logic [1:0]  r;
      logic [31:0] d, w;
      int          p;
      logic        v;
      p = $urandom(47617);
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      check({25'h0, gpioOe}, 32'h0);
      axiRd(`GOM_ADDR_PORTCFG, d, r);
      check(d, `GOM_PORTCFG_RESET);
      axiRd(`GOM_ADDR_LAST_PIN, d, r);
      check(d, `GOM_PIN_RESET);
      axiWr(`GOM_ADDR_PORTCFG, 32'h0000_0033, r);   // both ports in the pass select
      $display("test reset done");
      // four defined groups, two reserved groups and every code on a random pin with random sources
      foreach (grp[g])
      begin
         for (int f = 0; f < 8; f++)
         begin
            p = $urandom_range(6);
            v = 1'($urandom);
            rxStatus <= 8'($urandom);
            nextVal <= 8'($urandom);
            {frameSynchronization, deviceIrq, txIrq, txFrameValid, txLineValid, rxPortsSynced} <= 6'($urandom);
            w = {21'h0, grp[g], 1'b0, 3'(f), 2'b00, v, 1'b1};
            axiWr(8'(4 * p), w, r);
            check(r, `GOM_RESP_OKAY);
            oeExp[p] = 1'b1;
            repeat (24) @(posedge clk);   // two frames plus sync and output flop
            check(gpioOut[p], expOut(grp[g], 3'(f), v));
            check({25'h0, gpioOe}, {25'h0, oeExp});
         end
      end
      $display("test source sweep done");
      axiRd(8'(4 * p), d, r);
      check(d, w);
      axiRd(8'h28, d, r);   // unmapped place
      check(d, 32'h0000_0000);
      check({30'h0, r}, {30'h0, `GOM_RESP_SLVERR});
      axiWr(8'h28, 32'hFFFF_FFFF, r);
      check(r, `GOM_RESP_SLVERR);
      axiWr(8'(4 * p), 32'h0, r);   // switch the pin back to input
      oeExp[p] = 1'b0;
      repeat (4) @(posedge clk);
      check({25'h0, gpioOe}, {25'h0, oeExp});
      $display("test bus and disable done");
      // four linked values on port 0: gpio3 only arrives with count code 3
      axiWr(`GOM_ADDR_PORTCFG, 32'h0000_0333, r);
      axiWr(`GOM_ADDR_PIN0, 32'h0000_0031, r);   // pin 0 from port 0 gpio3
      nextVal <= 8'h08;
      repeat (80) @(posedge clk);   // five frames plus sync, well inside
      check({31'h0, gpioOut[0]}, 32'h1);
      // parallel video serializer on port 0: its values are refused
      axiWr(`GOM_ADDR_PORTCFG, 32'h0001_0333, r);
      repeat (8) @(posedge clk);
      check({31'h0, gpioOut[0]}, 32'h0);
      $display("test linked count and dvp done");
      sys_rst <= 1'b1;   // second reset mid run
      repeat (2) @(posedge clk);
      check({18'h0, gpioOut, gpioOe}, 32'h0);
      sys_rst <= 1'b0;
      // bus must answer again and config back at its reset value
      axiRd(`GOM_ADDR_PORTCFG, d, r);
      check(d, `GOM_PORTCFG_RESET);
      $display("test second reset done");
      summarize();
   end
endmodule // gom_output_mux_tb_top

`default_nettype wire
